// [logic/fcc_controller.sv]
// Purpose: flash command sequencer with byte register port
// Assumes: mode and protection inputs are synchronous to core_clk_i
// Notes: command checks are simplified to code, mode and address range
//
// What this block does
// - segment-count register reads 0x20, 0x28 or 0x40 by flash size
// - irq on done flag with enable, and on collision with enable
// - wait mode leaves controller running; done irq can wake
// - stop request waits for running command before granting stop
// - very-low-power modes ignore launches and set no error flags
// - launch in high-speed run sets access error
// - array read to busy block sets read collision flag
// - parameter bank writes ignored while done flag is zero
// - writing 1 to done flag launches; flag stays zero until finish
// - access or protection error blocks launch until cleared
// - unknown codes or out-of-range addresses set access error
// - program and erase into protected area set protection flag
// - failed checks skip execution and set done flag
// - run-time failure flag only reported when checks passed
// - results stored in bank and status before done flag sets
// - decode 0x01, 0x02, 0x03 as verify, program check, resource
// - decode 0x06 program longword and 0x09 sector erase
// - 0x41 read once and 0x43 program once within 64-byte field
// - 0x40, 0x44, 0x45 release security on success
// - erase all only runs when no region is protected
// - special secured allows only 0x40, 0x44; mass-erase lock none
// - protect bit 0 means protected, 1 unprotected
`timescale 1ns/1ns
`default_nettype none
module fcc_controller #(
    parameter int SEGMENTS = 32,
    parameter logic [23:0] FLASH_BYTES = 24'h020000,
    parameter int EXEC_CYCLES = 8
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // operating modes
    input wire logic nvm_special_i,
    input wire logic secured_i,
    input wire logic [1:0] mass_erase_enable_field_i,
    input wire logic very_low_power_i,
    input wire logic high_speed_run_i,
    input wire logic stop_req_i,
    output logic stop_ack_o,
    // protection
    input wire logic [31:0] region_protect_bits_i,
    // array read side
    input wire logic array_read_i,
    input wire logic array_fail_i,
    input wire logic [31:0] array_rdata_i,
    // security release and interrupts
    output logic security_release_o,
    output logic done_irq_o,
    output logic collision_irq_o
);
    // no encoding for other counts
    if (SEGMENTS != 32 && SEGMENTS != 40 && SEGMENTS != 64) begin : g_bad_seg
        $error("SEGMENTS must be 32, 40 or 64");
    end

    typedef struct packed {
        fcc_pkg::fcc_state_type st;
        logic done;
        logic coll;
        logic acc;
        logic prot;
        logic fail;
        logic done_ie;
        logic coll_ie;
        logic stop_ack;
        logic sec_rel;
        logic [7:0] seg_count;
        logic [7:0] rdata;
        logic [11:0][7:0] bank;
    } fcc_ctl_type;

    fcc_ctl_type r;
    fcc_ctl_type next_r;
    fcc_exec_if ex ();

    logic [7:0] code;
    logic [23:0] addr;
    logic [4:0] region;
    logic known;
    logic allowed;
    logic addr_bad;
    logic is_pe;
    logic launch;
    logic [3:0] bidx;

    // address to protection region
    function automatic logic [4:0] region_of(input logic [23:0] a);
        logic [47:0] p;
        p = 48'(a) * 48'(fcc_pkg::PROT_REGIONS);
        return 5'(p / 48'(FLASH_BYTES));
    endfunction

    // segment count encoding by size
    function automatic logic [7:0] seg_enc(input int n);
        return (n == 64) ? fcc_pkg::SEG_64 :
            (n == 40) ? fcc_pkg::SEG_40 : fcc_pkg::SEG_32;
    endfunction

    assign code = r.bank[0];
    assign addr = {r.bank[1], r.bank[2], r.bank[3]};
    assign region = region_of(addr);
    assign bidx = 4'(reg_addr_i - fcc_pkg::OFS_BANK0);

    // command decode
    always_comb begin
        unique case (code)
            fcc_pkg::CMD_RD1_SECTION, fcc_pkg::CMD_PGM_CHECK,
            fcc_pkg::CMD_RD_RESOURCE, fcc_pkg::CMD_PGM_LONG,
            fcc_pkg::CMD_ERASE_SECTOR, fcc_pkg::CMD_RD1_ALL,
            fcc_pkg::CMD_RD_ONCE, fcc_pkg::CMD_PGM_ONCE,
            fcc_pkg::CMD_ERASE_ALL, fcc_pkg::CMD_BACKDOOR: known = 1'b1;
            default: known = 1'b0;
        endcase
    end

    // mode availability and parameter checks
    always_comb begin
        allowed = 1'b1;
        if (nvm_special_i) begin
            if (mass_erase_enable_field_i == fcc_pkg::MASS_ERASE_LOCK) begin
                allowed = 1'b0;
            end else if (secured_i) begin
                allowed = (code == fcc_pkg::CMD_RD1_ALL) ||
                    (code == fcc_pkg::CMD_ERASE_ALL);
            end
        end
        addr_bad = 1'b0;
        if (code == fcc_pkg::CMD_RD_ONCE || code == fcc_pkg::CMD_PGM_ONCE) begin
            addr_bad = (r.bank[1] >= fcc_pkg::ONCE_RECORDS);
        end else if (code != fcc_pkg::CMD_RD_RESOURCE &&
                     code != fcc_pkg::CMD_RD1_ALL &&
                     code != fcc_pkg::CMD_ERASE_ALL &&
                     code != fcc_pkg::CMD_BACKDOOR) begin
            addr_bad = (addr >= FLASH_BYTES);
        end
        is_pe = (code == fcc_pkg::CMD_PGM_LONG) ||
            (code == fcc_pkg::CMD_ERASE_SECTOR);
    end

    // launch request: write of 1 to done flag while done reads 1
    assign launch = reg_wr_i && (reg_addr_i == fcc_pkg::OFS_STATUS) &&
        reg_wdata_i[fcc_pkg::STAT_DONE] && r.done;

    // sequencer and register file
    always_comb begin
        next_r = r;
        next_r.sec_rel = 1'b0;
        // collision from array read during command
        if (array_read_i && !r.done) begin
            next_r.coll = 1'b1;
        end
        // register writes
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                fcc_pkg::OFS_STATUS: begin
                    if (reg_wdata_i[fcc_pkg::STAT_COLL] && !next_r.coll) begin
                        next_r.coll = 1'b0;
                    end
                    // set beats clear
                    if (reg_wdata_i[fcc_pkg::STAT_COLL] &&
                        !(array_read_i && !r.done)) begin
                        next_r.coll = 1'b0;
                    end
                    if (reg_wdata_i[fcc_pkg::STAT_ACC]) begin
                        next_r.acc = 1'b0;
                    end
                    if (reg_wdata_i[fcc_pkg::STAT_PROT]) begin
                        next_r.prot = 1'b0;
                    end
                end
                fcc_pkg::OFS_CONFIG: begin
                    next_r.done_ie = reg_wdata_i[fcc_pkg::CFG_DONE_IE];
                    next_r.coll_ie = reg_wdata_i[fcc_pkg::CFG_COLL_IE];
                end
                default: begin
                    if (reg_addr_i >= fcc_pkg::OFS_BANK0 &&
                        reg_addr_i <= fcc_pkg::OFS_BANK_LAST && r.done) begin
                        next_r.bank[bidx] = reg_wdata_i;
                    end
                end
            endcase
        end
        // launch handling
        if (launch && !very_low_power_i) begin
            if (high_speed_run_i) begin
                next_r.acc = 1'b1;
            end else if (!r.acc && !r.prot) begin
                next_r.done = 1'b0;
                next_r.fail = 1'b0;
                next_r.st = fcc_pkg::FCC_CHECK;
            end
        end
        unique case (r.st)
            fcc_pkg::FCC_IDLE: begin
            end
            fcc_pkg::FCC_CHECK: begin
                if (!known || !allowed || addr_bad) begin
                    next_r.acc = 1'b1;
                    next_r.st = fcc_pkg::FCC_FINISH;
                end else if ((is_pe && !region_protect_bits_i[region]) ||
                             (code == fcc_pkg::CMD_ERASE_ALL &&
                              !(&region_protect_bits_i))) begin
                    next_r.prot = 1'b1;
                    next_r.st = fcc_pkg::FCC_FINISH;
                end else begin
                    next_r.st = fcc_pkg::FCC_EXEC;
                end
            end
            fcc_pkg::FCC_EXEC: begin
                if (ex.done) begin
                    next_r.fail = ex.fail;
                    if (code == fcc_pkg::CMD_RD_RESOURCE ||
                        code == fcc_pkg::CMD_RD_ONCE) begin
                        next_r.bank[4] = ex.rdata[31:24];
                        next_r.bank[5] = ex.rdata[23:16];
                        next_r.bank[6] = ex.rdata[15:8];
                        next_r.bank[7] = ex.rdata[7:0];
                    end
                    if (!ex.fail && (code == fcc_pkg::CMD_RD1_ALL ||
                        code == fcc_pkg::CMD_ERASE_ALL ||
                        code == fcc_pkg::CMD_BACKDOOR)) begin
                        next_r.sec_rel = 1'b1;
                    end
                    next_r.st = fcc_pkg::FCC_FINISH;
                end
            end
            fcc_pkg::FCC_FINISH: begin
                next_r.done = 1'b1;
                next_r.st = fcc_pkg::FCC_IDLE;
            end
        endcase
        // stop granted only with no command running
        next_r.stop_ack = stop_req_i && next_r.done;
        // register read data
        next_r.rdata = 8'h00;
        if (reg_rd_i) begin
            if (reg_addr_i == fcc_pkg::OFS_STATUS) begin
                next_r.rdata = {r.done, r.coll, r.acc, r.prot, 3'h0, r.fail};
            end else if (reg_addr_i == fcc_pkg::OFS_CONFIG) begin
                next_r.rdata = {r.done_ie, r.coll_ie, 6'h00};
            end else if (reg_addr_i == fcc_pkg::OFS_SEGMENT_COUNT_INFO) begin
                next_r.rdata = r.seg_count;
            end else if (reg_addr_i >= fcc_pkg::OFS_BANK0 &&
                         reg_addr_i <= fcc_pkg::OFS_BANK_LAST) begin
                next_r.rdata = r.bank[bidx];
            end
        end
    end

    // state register; segment count loaded during reset
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r <= '0;
            r.done <= 1'b1;
            r.st <= fcc_pkg::FCC_IDLE;
            // readable straight out of reset
            r.seg_count <= seg_enc(SEGMENTS);
        end else begin
            r <= next_r;
        end
    end

    // execution engine runs independent of wait mode
    assign ex.start = (r.st == fcc_pkg::FCC_CHECK) &&
        (next_r.st == fcc_pkg::FCC_EXEC);
    assign ex.code = code;
    assign ex.addr = addr;
    assign ex.wdata = {r.bank[8], r.bank[9], r.bank[10], r.bank[11]};

    fcc_exec_engine #(
        .EXEC_CYCLES(EXEC_CYCLES)
    ) u_engine (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .ex(ex.eng),
        .array_fail_i(array_fail_i),
        .array_rdata_i(array_rdata_i)
    );

    // outputs
    assign reg_rdata_o = r.rdata;
    assign stop_ack_o = r.stop_ack;
    assign security_release_o = r.sec_rel;
    assign done_irq_o = r.done && r.done_ie;
    assign collision_irq_o = r.coll && r.coll_ie;
endmodule : fcc_controller
`default_nettype wire

// [logic/fcc_pkg.sv]
// Purpose: shared constants and types of the flash command controller
// Assumes: byte-wide register port, fixed byte offsets
// Notes: segment-count encodings selected by a size parameter
package fcc_pkg;
    // register offsets (byte addresses)
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_CONFIG = 8'h01;
    localparam logic [7:0] OFS_BANK0 = 8'h04;
    localparam logic [7:0] OFS_BANK_LAST = 8'h0F;
    localparam logic [7:0] OFS_SEGMENT_COUNT_INFO = 8'h2B;
    // status register field positions
    localparam int STAT_DONE = 7;
    localparam int STAT_COLL = 6;
    localparam int STAT_ACC = 5;
    localparam int STAT_PROT = 4;
    localparam int STAT_FAIL = 0;
    // config register field positions
    localparam int CFG_DONE_IE = 7;
    localparam int CFG_COLL_IE = 6;
    // segment count encodings
    localparam logic [7:0] SEG_32 = 8'h20;
    localparam logic [7:0] SEG_40 = 8'h28;
    localparam logic [7:0] SEG_64 = 8'h40;
    // command codes
    localparam logic [7:0] CMD_RD1_SECTION = 8'h01;
    localparam logic [7:0] CMD_PGM_CHECK = 8'h02;
    localparam logic [7:0] CMD_RD_RESOURCE = 8'h03;
    localparam logic [7:0] CMD_PGM_LONG = 8'h06;
    localparam logic [7:0] CMD_ERASE_SECTOR = 8'h09;
    localparam logic [7:0] CMD_RD1_ALL = 8'h40;
    localparam logic [7:0] CMD_RD_ONCE = 8'h41;
    localparam logic [7:0] CMD_PGM_ONCE = 8'h43;
    localparam logic [7:0] CMD_ERASE_ALL = 8'h44;
    localparam logic [7:0] CMD_BACKDOOR = 8'h45;
    // mass-erase field value that locks special mode
    localparam logic [1:0] MASS_ERASE_LOCK = 2'h2;
    // one-time field: 64 bytes as 16 four-byte records
    localparam logic [7:0] ONCE_RECORDS = 8'h10;
    // protection regions
    localparam int PROT_REGIONS = 32;
    // reset value of bank
    localparam logic [7:0] BANK_RESET = 8'h00;
    // controller states
    typedef enum logic [1:0] {
        FCC_IDLE = 2'b00,
        FCC_CHECK = 2'b01,
        FCC_EXEC = 2'b10,
        FCC_FINISH = 2'b11
    } fcc_state_type;
endpackage : fcc_pkg

// [logic/fcc_exec_if.sv]
// Purpose: handshake between sequencer and array execution engine
// Assumes: single clock
// Notes: start is a pulse, done is a pulse with fail
`timescale 1ns/1ns
`default_nettype none
interface fcc_exec_if;
    logic start;
    logic [7:0] code;
    logic [23:0] addr;
    logic [31:0] wdata;
    logic done;
    logic fail;
    logic [31:0] rdata;
    // sequencer side
    modport seq (output start, code, addr, wdata, input done, fail, rdata);
    // engine side
    modport eng (input start, code, addr, wdata, output done, fail, rdata);
endinterface : fcc_exec_if
`default_nettype wire

// [logic/fcc_exec_engine.sv]
// Purpose: array execution stand-in that runs one command for a count
// Assumes: array timing is outside this block; busy for EXEC_CYCLES
// Notes: failure and read data come from the array side inputs
`timescale 1ns/1ns
`default_nettype none
module fcc_exec_engine #(
    parameter int EXEC_CYCLES = 8
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // sequencer link
    fcc_exec_if.eng ex,
    // array results
    input wire logic array_fail_i,
    input wire logic [31:0] array_rdata_i
);
    if (EXEC_CYCLES < 1 || EXEC_CYCLES > 255) begin : g_bad_cycles
        $error("EXEC_CYCLES out of range");
    end

    typedef struct packed {
        logic busy;
        logic [7:0] cnt;
        logic done;
        logic fail;
        logic [31:0] rdata;
    } fcc_eng_type;

    fcc_eng_type r;
    fcc_eng_type next_r;

    // count down the command, then report once
    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        if (!r.busy && ex.start) begin
            next_r.busy = 1'b1;
            next_r.cnt = 8'(EXEC_CYCLES);
        end else if (r.busy) begin
            next_r.cnt = r.cnt - 8'h01;
            if (r.cnt == 8'h01) begin
                next_r.busy = 1'b0;
                next_r.done = 1'b1;
                next_r.fail = array_fail_i;
                next_r.rdata = array_rdata_i;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign ex.done = r.done;
    assign ex.fail = r.fail;
    assign ex.rdata = r.rdata;
endmodule : fcc_exec_engine
`default_nettype wire

// [verification/fcc_controller_sva.sv]
// Purpose: port-level checks for the flash command controller
// Assumes: config enables reset to zero; done irq enabled while busy
// Notes: bound into fcc_controller after the module
`timescale 1ns/1ns
`default_nettype none
module fcc_controller_sva #(
    parameter int SEGMENTS = 32
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    // modes and array side
    input wire logic very_low_power_i,
    input wire logic stop_req_i,
    input wire logic stop_ack_o,
    input wire logic array_read_i,
    // events
    input wire logic security_release_o,
    input wire logic done_irq_o,
    input wire logic collision_irq_o
);
    localparam logic [7:0] SEG_EXP = (SEGMENTS == 64) ? fcc_pkg::SEG_64 :
        (SEGMENTS == 40) ? fcc_pkg::SEG_40 : fcc_pkg::SEG_32;
    logic [1:0] ie;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    // shadow of the two interrupt enables
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ie <= 2'h0;
        end else if (reg_wr_i && reg_addr_i == fcc_pkg::OFS_CONFIG) begin
            ie <= reg_wdata_i[7:6];
        end
    end
    a_seg_count_read: assert property ($past(reg_rd_i) &&
        $past(reg_addr_i) == fcc_pkg::OFS_SEGMENT_COUNT_INFO
        |-> reg_rdata_o == SEG_EXP) else $error("segment count wrong");
    a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data not zero when idle");
    a_done_irq_mask: assert property (!ie[1] |-> !done_irq_o)
        else $error("done irq while disabled");
    a_coll_irq_mask: assert property (!ie[0] |-> !collision_irq_o)
        else $error("collision irq while disabled");
    a_coll_irq_cause: assert property ($rose(collision_irq_o)
        |-> $past(array_read_i) || $past(reg_wr_i))
        else $error("collision irq without cause");
    a_launch_busy: assert property ($fell(done_irq_o) && ie[1]
        && $past(ie[1]) |=> !done_irq_o) else $error("done back too soon");
    a_done_bounded: assert property ($fell(done_irq_o) && ie[1]
        |-> ##[1:60] (done_irq_o || !ie[1])) else $error("command hung");
    a_vlp_refused: assert property (very_low_power_i && done_irq_o
        && reg_wr_i && reg_addr_i == fcc_pkg::OFS_STATUS
        |=> done_irq_o [*3]) else $error("launch taken in low power");
    a_stop_needs_req: assert property (stop_ack_o |-> $past(stop_req_i))
        else $error("stop granted without request");
    a_stop_busy: assert property ($fell(done_irq_o) && ie[1]
        |=> !stop_ack_o) else $error("stop granted while busy");
    a_sec_pulse: assert property (security_release_o
        |=> !security_release_o) else $error("release longer than pulse");
endmodule // fcc_controller_sva

bind fcc_controller fcc_controller_sva #(.SEGMENTS(SEGMENTS))
    u_fcc_controller_sva (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .very_low_power_i(very_low_power_i),
    .stop_req_i(stop_req_i), .stop_ack_o(stop_ack_o),
    .array_read_i(array_read_i), .security_release_o(security_release_o),
    .done_irq_o(done_irq_o), .collision_irq_o(collision_irq_o)
);
`default_nettype wire

// [verification/fcc_cpu_model.sv]
// Purpose: processor stand-in issuing byte register accesses
// Assumes: one access at a time, strobes held over one rising edge
// Notes: released write data shows the inverse of the last value
`timescale 1ns/1ns
`default_nettype none
module fcc_cpu_model (
    // clock
    input wire logic core_clk_i,
    // register port toward the controller
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    input wire logic [7:0] reg_rdata_i
);
    // idle bus from time zero
    initial begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
    end
    // one write, launched after a falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk_i);
        reg_wr_o = 1'b1;
        reg_addr_o = a;
        reg_wdata_o = d;
        @(negedge core_clk_i);
        reg_wr_o = 1'b0;
        reg_wdata_o = ~d;
    endtask
    // one read, data taken the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk_i);
        reg_rd_o = 1'b1;
        reg_addr_o = a;
        @(negedge core_clk_i);
        reg_rd_o = 1'b0;
        d = reg_rdata_i;
    endtask
endmodule // fcc_cpu_model
`default_nettype wire

// [verification/testbench.sv]
// Purpose: self-checking bench for the flash command controller
// Assumes: execution count shortened to 2; enables kept on while busy
// Notes: reads are scored against a queue of expected values
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam logic [7:0] CODES [7] = '{8'h01, 8'h02, 8'h03, 8'h06,
        8'h09, 8'h41, 8'h43};
    logic core_clk_i, rst_n_i, reg_wr, reg_rd, rd_d;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, last_rd;
    logic special, secured, vlp, hsr, stop_req, stop_ack, arr_read, arr_fail;
    logic sec_rel, done_irq, coll_irq;
    logic [1:0] mass;
    logic [31:0] prot, arr_rdata;
    logic [23:0] addr;
    logic [8:0] exp_q[$];
    logic [8:0] exp_n;
    int n_errors = 0;
    int n_compared = 0;
    int n_sec = 0;
    int seed_v, base;
    // free-running core clock
    initial begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end
    fcc_controller #(.SEGMENTS(32), .FLASH_BYTES(24'h020000),
        .EXEC_CYCLES(2)) u_fcc_controller (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr),
        .reg_rd_i(reg_rd), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_rdata_o(reg_rdata), .nvm_special_i(special),
        .secured_i(secured), .mass_erase_enable_field_i(mass),
        .very_low_power_i(vlp), .high_speed_run_i(hsr),
        .stop_req_i(stop_req), .stop_ack_o(stop_ack),
        .region_protect_bits_i(prot), .array_read_i(arr_read),
        .array_fail_i(arr_fail), .array_rdata_i(arr_rdata),
        .security_release_o(sec_rel), .done_irq_o(done_irq),
        .collision_irq_o(coll_irq));
    fcc_cpu_model u_fcc_cpu_model (.core_clk_i(core_clk_i),
        .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_addr_o(reg_addr),
        .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata));
    // read strobe delay and release pulse count
    always @(posedge core_clk_i) begin
        rd_d <= reg_rd;
        if (sec_rel === 1'b1) n_sec <= n_sec + 1;
    end
    // pop the oldest note for each read; score only notes flagged for checking
    always @(negedge core_clk_i) begin
        if (rd_d === 1'b1 && exp_q.size() > 0) begin
            exp_n = exp_q.pop_front();
            if (exp_n[8]) cmp8(reg_rdata, exp_n[7:0]);
        end
    end
    task automatic cmp8(input logic [7:0] a, input logic [7:0] e);
        n_compared++;
        if (a !== e) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, a, e);
        end
    endtask
    task automatic cmp1(input logic a, input logic e);
        n_compared++;
        if (a !== e) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, a, e);
        end
    endtask
    task automatic rdx(input logic [7:0] a, input logic [7:0] e, input bit c);
        exp_q.push_back({c, e});
        u_fcc_cpu_model.rd(a, last_rd);
    endtask
    // poll status until the done bit reads one
    task automatic wait_done;
        int i;
        i = 0;
        last_rd = 8'h00;
        while (last_rd[7] !== 1'b1 && i < 40) begin
            rdx(fcc_pkg::OFS_STATUS, 8'h00, 1'b0);
            i++;
        end
        if (last_rd[7] !== 1'b1) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, i, 40);
        end
    endtask
    // load code and address in a randomly rotated order, then launch
    task automatic launch(input logic [7:0] code, input logic [23:0] a);
        logic [7:0] b [4];
        int r;
        b = '{code, a[23:16], a[15:8], a[7:0]};
        r = $urandom % 4;
        for (int i = 0; i < 4; i++) begin
            u_fcc_cpu_model.wr(8'(4 + (i + r) % 4), b[(i + r) % 4]);
        end
        u_fcc_cpu_model.wr(fcc_pkg::OFS_STATUS, 8'h80);
    endtask
    // full command with status check and flag clear
    task automatic cmd(input logic [7:0] c, input logic [23:0] a,
        input logic [7:0] e);
        launch(c, a);
        wait_done;
        rdx(fcc_pkg::OFS_STATUS, e, 1'b1);
        u_fcc_cpu_model.wr(fcc_pkg::OFS_STATUS, 8'h70);
    endtask
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // watchdog against a hung sequence
    initial begin
        repeat (20000) @(posedge core_clk_i);
        n_errors++;
        $display("watchdog expired at %0t", $time);
        end_of_test;
    end
    // main sequence
    initial begin
        {rst_n_i, special, secured, vlp, hsr, stop_req, arr_read} = 7'h00;
        {arr_fail, mass, arr_rdata} = 35'h0;
        prot = 32'hFFFFFFFF;
        repeat (4) @(posedge core_clk_i);
        @(negedge core_clk_i);
        rst_n_i = 1'b1;
        seed_v = $urandom(47);
        rdx(fcc_pkg::OFS_SEGMENT_COUNT_INFO, fcc_pkg::SEG_32, 1'b1);
        rdx(fcc_pkg::OFS_STATUS, 8'h80, 1'b1);
        u_fcc_cpu_model.wr(fcc_pkg::OFS_CONFIG, 8'hC0);
        cmp1(done_irq, 1'b1);
        $display("test reset done");
        arr_fail = 1'b1;
        launch(fcc_pkg::CMD_RD1_SECTION, 24'h000100);
        stop_req = 1'b1;
        @(negedge core_clk_i);
        cmp1(done_irq, 1'b0);
        arr_read = 1'b1;
        @(negedge core_clk_i);
        arr_read = 1'b0;
        cmp1(coll_irq, 1'b1);
        cmp1(stop_ack, 1'b0);
        u_fcc_cpu_model.wr(8'h05, 8'hFF);
        wait_done;
        cmp1(stop_ack, 1'b1);
        rdx(fcc_pkg::OFS_STATUS, 8'hC1, 1'b1);
        rdx(8'h05, 8'h00, 1'b1);
        stop_req = 1'b0;
        u_fcc_cpu_model.wr(fcc_pkg::OFS_STATUS, 8'h70);
        cmp1(coll_irq, 1'b0);
        u_fcc_cpu_model.wr(fcc_pkg::OFS_CONFIG, 8'h40);
        cmp1(done_irq, 1'b0);
        u_fcc_cpu_model.wr(fcc_pkg::OFS_CONFIG, 8'hC0);
        $display("test busy done");
        arr_fail = 1'b0;
        for (int i = 0; i < 7; i++) begin
            arr_rdata = $urandom;
            addr = 24'($urandom) & 24'h01FFF8;
            if (CODES[i] == 8'h41 || CODES[i] == 8'h43) addr = {8'(i), 16'h0};
            cmd(CODES[i], addr, 8'h80);
            if (CODES[i] == 8'h03 || CODES[i] == 8'h41) begin
                for (int k = 0; k < 4; k++) begin
                    rdx(8'(8 + k), arr_rdata[31 - 8 * k -: 8], 1'b1);
                end
            end
        end
        base = n_sec;
        cmd(fcc_pkg::CMD_RD1_ALL, 24'h0, 8'h80);
        cmd(fcc_pkg::CMD_ERASE_ALL, 24'h0, 8'h80);
        cmd(fcc_pkg::CMD_BACKDOOR, 24'h0, 8'h80);
        cmp8(8'(n_sec - base), 8'h03);
        $display("test codes done");
        arr_fail = 1'b1;
        cmd(8'h07, 24'h0, 8'hA0);
        launch(8'h07, 24'h0);
        wait_done;
        u_fcc_cpu_model.wr(fcc_pkg::OFS_STATUS, 8'h80);
        rdx(fcc_pkg::OFS_STATUS, 8'hA0, 1'b1);
        u_fcc_cpu_model.wr(fcc_pkg::OFS_STATUS, 8'h70);
        arr_fail = 1'b0;
        cmd(fcc_pkg::CMD_PGM_LONG, 24'hFF0000, 8'hA0);
        prot = 32'hFFFFFFFE;
        base = n_sec;
        cmd(fcc_pkg::CMD_ERASE_SECTOR, 24'h000000, 8'h90);
        cmd(fcc_pkg::CMD_ERASE_SECTOR, 24'h01F000, 8'h80);
        cmd(fcc_pkg::CMD_ERASE_ALL, 24'h0, 8'h90);
        cmp8(8'(n_sec - base), 8'h00);
        prot = 32'hFFFFFFFF;
        $display("test errors done");
        hsr = 1'b1;
        cmd(fcc_pkg::CMD_RD1_SECTION, 24'h000100, 8'hA0);
        hsr = 1'b0;
        vlp = 1'b1;
        u_fcc_cpu_model.wr(fcc_pkg::OFS_STATUS, 8'h80);
        cmp1(done_irq, 1'b1);
        rdx(fcc_pkg::OFS_STATUS, 8'h80, 1'b1);
        vlp = 1'b0;
        {special, secured} = 2'b11;
        cmd(fcc_pkg::CMD_RD1_SECTION, 24'h000100, 8'hA0);
        cmd(fcc_pkg::CMD_RD1_ALL, 24'h0, 8'h80);
        mass = fcc_pkg::MASS_ERASE_LOCK;
        cmd(fcc_pkg::CMD_RD1_ALL, 24'h0, 8'hA0);
        {special, secured, mass} = 4'h0;
        $display("test modes done");
        end_of_test;
    end
endmodule // testbench
`default_nettype wire
